// File: hdl/scsc_top.sv
// sample clock source selection, rate solver and control registers
`timescale 1ns/1ps
`default_nettype none
module scsc_top
#(
	parameter logic [31:0] QUARTZ_HZ = scsc_pkg::MAX_RATE_HZ,
	parameter logic LIMITED_VARIANT = 1'b1
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [3:0] chan_enable,
	output logic calc_busy,
	output logic loop_bypass,
	output logic loop_ref_external,
	output logic [31:0] loop_mult,
	output logic [31:0] loop_prediv,
	output logic [11:0] quartz_div,
	output logic sample_clk_from_connector,
	output logic connector_clk_drive,
	output logic connector_termination
);
	logic [31:0] rate_req_r, rate_req_nxt;
	logic loop_en_r, loop_en_nxt;
	logic direct_ext_r, direct_ext_nxt;
	logic clk_out_r, clk_out_nxt;
	logic term_r, term_nxt;
	logic [31:0] ref_r, ref_nxt;
	logic [3:0] chan_prev_r, chan_prev_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	logic pend_r, pend_nxt;

	logic [31:0] achieved_r, achieved_nxt;
	logic [31:0] step_r, step_nxt;
	logic [31:0] mult_r, mult_nxt;
	logic [11:0] qdiv_r, qdiv_nxt;
	logic [31:0] best_diff_r, best_diff_nxt;
	logic [4:0] idx_r, idx_nxt;
	logic [31:0] clamped_r, clamped_nxt;
	scsc_pkg::scsc_state_t state_r, state_nxt;

	logic div_start;
	logic [31:0] div_num, div_den, div_quot;
	logic div_done;
	logic [31:0] ref_hz, max_hz, req_clamped;
	logic [2:0] chan_count;
	logic [63:0] prod;
	logic [31:0] cand [scsc_pkg::QDIV_N];

	genvar gk;
	generate
		for (gk = 0; gk < scsc_pkg::QDIV_N; gk++)
		begin : g_cand
			assign cand[gk] = QUARTZ_HZ / {20'h0_0000, scsc_pkg::QDIV[gk]}; // RULE7
		end
	endgenerate

	assign ref_hz = (ref_r == 32'h0000_0000)
		? scsc_pkg::INT_REF_HZ : ref_r; // RULE1 RULE9
	assign chan_count = {2'b00, chan_enable[0]} + {2'b00, chan_enable[1]}
		+ {2'b00, chan_enable[2]} + {2'b00, chan_enable[3]};
	assign max_hz = (LIMITED_VARIANT && chan_count > 3'h1)
		? scsc_pkg::MAX_RATE_MULTI_HZ : scsc_pkg::MAX_RATE_HZ; // RULE5
	assign req_clamped = (rate_req_r < scsc_pkg::MIN_RATE_HZ)
		? scsc_pkg::MIN_RATE_HZ
		: ((rate_req_r > max_hz) ? max_hz : rate_req_r); // RULE4 RULE14
	assign prod = {32'h0000_0000, mult_r} * {32'h0000_0000, step_r};

	// register port and recalculation trigger
	always_comb
	begin
		rate_req_nxt = rate_req_r;
		loop_en_nxt = loop_en_r;
		direct_ext_nxt = direct_ext_r;
		clk_out_nxt = clk_out_r;
		term_nxt = term_r;
		ref_nxt = ref_r;
		chan_prev_nxt = chan_enable;
		rdata_nxt = rdata_r;
		rvalid_nxt = 1'b0;
		pend_nxt = pend_r;
		if (chan_enable != chan_prev_r)
			pend_nxt = 1'b1;
		if (reg_wr)
		begin
			if (reg_addr == scsc_pkg::OFS_RATE_REQUEST)
			begin
				rate_req_nxt = reg_wdata; // RULE2 RULE8
				pend_nxt = 1'b1;
			end
			else if (reg_addr == scsc_pkg::OFS_LOOP_ENABLE)
			begin
				loop_en_nxt = reg_wdata[0]; // RULE6
				pend_nxt = 1'b1;
			end
			else if (reg_addr == scsc_pkg::OFS_DIRECT_EXT)
				direct_ext_nxt = reg_wdata[0]; // RULE13
			else if (reg_addr == scsc_pkg::OFS_CLOCK_OUT)
				clk_out_nxt = reg_wdata[0];
			else if (reg_addr == scsc_pkg::OFS_TERMINATION)
				term_nxt = reg_wdata[0];
			else if (reg_addr == scsc_pkg::OFS_REFERENCE)
			begin
				ref_nxt = reg_wdata; // RULE9 RULE11
				pend_nxt = 1'b1;
			end
		end
		// a new trigger in the same cycle keeps the request pending
		if (state_r == scsc_pkg::SCSC_IDLE && pend_r && !reg_wr
			&& chan_enable == chan_prev_r)
			pend_nxt = 1'b0;
		if (reg_rd)
		begin
			rvalid_nxt = 1'b1;
			if (reg_addr == scsc_pkg::OFS_RATE_REQUEST)
				rdata_nxt = achieved_r; // RULE2 RULE8
			else if (reg_addr == scsc_pkg::OFS_LOOP_ENABLE)
				rdata_nxt = {31'h0000_0000, loop_en_r};
			else if (reg_addr == scsc_pkg::OFS_DIRECT_EXT)
				rdata_nxt = {31'h0000_0000, direct_ext_r};
			else if (reg_addr == scsc_pkg::OFS_CLOCK_OUT)
				rdata_nxt = {31'h0000_0000, clk_out_r};
			else if (reg_addr == scsc_pkg::OFS_TERMINATION)
				rdata_nxt = {31'h0000_0000, term_r};
			else if (reg_addr == scsc_pkg::OFS_REFERENCE)
				rdata_nxt = ref_r;
			else
				rdata_nxt = 32'h0000_0000;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rate_req_r <= scsc_pkg::RST_RATE_REQUEST;
			loop_en_r <= scsc_pkg::RST_LOOP_ENABLE; // RULE6
			direct_ext_r <= 1'b0;
			clk_out_r <= 1'b0;
			term_r <= 1'b0;
			ref_r <= scsc_pkg::RST_REFERENCE;
			chan_prev_r <= 4'h0;
			rdata_r <= 32'h0000_0000;
			rvalid_r <= 1'b0;
			pend_r <= 1'b1;
		end
		else
		begin
			rate_req_r <= rate_req_nxt;
			loop_en_r <= loop_en_nxt;
			direct_ext_r <= direct_ext_nxt;
			clk_out_r <= clk_out_nxt;
			term_r <= term_nxt;
			ref_r <= ref_nxt;
			chan_prev_r <= chan_prev_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			pend_r <= pend_nxt;
		end
	end

	// rate solver: loop step = reference / prediv, multiplier rounds to nearest
	always_comb
	begin
		logic [31:0] diff;
		diff = 32'h0000_0000;
		state_nxt = state_r;
		achieved_nxt = achieved_r;
		step_nxt = step_r;
		mult_nxt = mult_r;
		qdiv_nxt = qdiv_r;
		best_diff_nxt = best_diff_r;
		idx_nxt = idx_r;
		clamped_nxt = clamped_r;
		div_start = 1'b0;
		div_num = ref_hz;
		div_den = scsc_pkg::LOOP_PREDIV;
		case (state_r)
			scsc_pkg::SCSC_IDLE:
			begin
				if (pend_r)
				begin
					clamped_nxt = req_clamped;
					idx_nxt = 5'h00;
					best_diff_nxt = 32'hffff_ffff;
					state_nxt = loop_en_r ? scsc_pkg::SCSC_STEP
						: scsc_pkg::SCSC_QSCAN; // RULE6
				end
			end
			scsc_pkg::SCSC_STEP:
			begin
				div_start = 1'b1; // RULE11
				state_nxt = scsc_pkg::SCSC_STEP_W;
			end
			scsc_pkg::SCSC_STEP_W:
			begin
				if (div_done)
				begin
					step_nxt = (div_quot == 32'h0000_0000) ? 32'h0000_0001
						: div_quot;
					state_nxt = scsc_pkg::SCSC_MULT;
				end
			end
			scsc_pkg::SCSC_MULT:
			begin
				div_num = clamped_r + {1'b0, step_r[31:1]}; // RULE11
				div_den = step_r;
				div_start = 1'b1;
				state_nxt = scsc_pkg::SCSC_MULT_W;
			end
			scsc_pkg::SCSC_MULT_W:
			begin
				div_num = clamped_r + {1'b0, step_r[31:1]};
				div_den = step_r;
				if (div_done)
				begin
					mult_nxt = div_quot;
					state_nxt = scsc_pkg::SCSC_FIX;
				end
			end
			scsc_pkg::SCSC_FIX:
			begin
				// keep the product inside the legal window
				if (prod[31:0] > max_hz || prod[63:32] != 32'h0000_0000)
					mult_nxt = mult_r - 32'h0000_0001; // RULE5 RULE14
				else if (prod[31:0] < scsc_pkg::MIN_RATE_HZ)
					mult_nxt = mult_r + 32'h0000_0001; // RULE4
				else
				begin
					achieved_nxt = prod[31:0];
					state_nxt = scsc_pkg::SCSC_IDLE;
				end
			end
			scsc_pkg::SCSC_QSCAN:
			begin
				diff = (cand[idx_r] > clamped_r) ? cand[idx_r] - clamped_r
					: clamped_r - cand[idx_r];
				if (cand[idx_r] <= max_hz && cand[idx_r] >= scsc_pkg::MIN_RATE_HZ
					&& diff < best_diff_r)
				begin
					best_diff_nxt = diff; // RULE8
					achieved_nxt = cand[idx_r];
					qdiv_nxt = scsc_pkg::QDIV[idx_r]; // RULE7
				end
				idx_nxt = idx_r + 5'h01;
				if (idx_r == 5'(scsc_pkg::QDIV_N - 1))
					state_nxt = scsc_pkg::SCSC_IDLE;
			end
			default:
				state_nxt = scsc_pkg::SCSC_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= scsc_pkg::SCSC_IDLE;
			achieved_r <= 32'h0000_0000;
			step_r <= 32'h0000_0001;
			mult_r <= 32'h0000_0000;
			qdiv_r <= 12'h001;
			best_diff_r <= 32'hffff_ffff;
			idx_r <= 5'h00;
			clamped_r <= 32'h0000_0000;
		end
		else
		begin
			state_r <= state_nxt;
			achieved_r <= achieved_nxt;
			step_r <= step_nxt;
			mult_r <= mult_nxt;
			qdiv_r <= qdiv_nxt;
			best_diff_r <= best_diff_nxt;
			idx_r <= idx_nxt;
			clamped_r <= clamped_nxt;
		end
	end

	scsc_divider u_div
	(
		.mclk(mclk),
		.resetn(resetn),
		.start(div_start),
		.num(div_num),
		.den(div_den),
		.done(div_done),
		.quot(div_quot)
	);

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;
	assign calc_busy = pend_r || (state_r != scsc_pkg::SCSC_IDLE);
	assign loop_bypass = !loop_en_r; // RULE6
	assign loop_ref_external = (ref_r != 32'h0000_0000); // RULE9
	assign loop_mult = mult_r;
	assign loop_prediv = scsc_pkg::LOOP_PREDIV;
	assign quartz_div = qdiv_r;
	assign sample_clk_from_connector = direct_ext_r; // RULE13
	assign connector_clk_drive = clk_out_r && !direct_ext_r
		&& (ref_r == 32'h0000_0000); // RULE3
	assign connector_termination = term_r
		&& (direct_ext_r || ref_r != 32'h0000_0000); // RULE12
endmodule : scsc_top
`default_nettype wire

// File: hdl/scsc_pkg.sv
// constants shared by the sample clock source control block
// Notes on behaviour
// (RULE1) by default loop and dividers run from the on-board 40 MHz reference; the quartz divider candidates here use QUARTZ_HZ, 125 MHz
// (RULE2) rate request written in hertz; read returns nearest achievable rate
// (RULE3) connector clock output only when enabled with internal clocking
// (RULE4) no internal sample rate below 1 kHz
// (RULE5) top rate depends on variant and channels; 125 or 62.5 MS/s
// (RULE6) loop enable resets to one; zero bypasses loop for quartz division
// (RULE7) bypassed rate is quartz divided by a member of the divider set
// (RULE8) bypassed mode still accepts a request and reports best divider rate
// (RULE9) reference zero selects internal source; nonzero is external hertz
// (RULE10) outside source supplies 1 to 125 MHz and programs that exact value
// (RULE11) loop settings come from reference and rate request together
// (RULE12) termination loads the connector only while it serves as an input
// (RULE13) direct external clock select makes the connector the sample clock
// (RULE14) requests outside achievable range clamp to nearest reachable rate
package scsc_pkg;
	localparam logic [15:0] OFS_RATE_REQUEST = 16'h4e20;
	localparam logic [15:0] OFS_LOOP_ENABLE = 16'h4e3e;
	localparam logic [15:0] OFS_DIRECT_EXT = 16'h4e84;
	localparam logic [15:0] OFS_CLOCK_OUT = 16'h4e8e;
	localparam logic [15:0] OFS_TERMINATION = 16'h4e98;
	localparam logic [15:0] OFS_REFERENCE = 16'h4eac;

	localparam logic [31:0] RST_RATE_REQUEST = 32'h0000_0000;
	localparam logic RST_LOOP_ENABLE = 1'b1;
	localparam logic [31:0] RST_REFERENCE = 32'h0000_0000;

	localparam logic [31:0] INT_REF_HZ = 32'h0262_5a00;
	localparam logic [31:0] MIN_RATE_HZ = 32'h0000_03e8;
	localparam logic [31:0] MAX_RATE_HZ = 32'h0773_5940;
	localparam logic [31:0] MAX_RATE_MULTI_HZ = 32'h03b9_aca0;
	localparam logic [31:0] LOOP_PREDIV = 32'h0000_9c40;

	localparam int QDIV_N = 17;
	localparam logic [11:0] QDIV [QDIV_N] = '{
		12'h001, 12'h002, 12'h004, 12'h008, 12'h00a, 12'h010,
		12'h014, 12'h028, 12'h032, 12'h050, 12'h064, 12'h0c8,
		12'h190, 12'h1f4, 12'h320, 12'h3e8, 12'h7d0};

	typedef enum logic [2:0] {
		SCSC_IDLE, SCSC_STEP, SCSC_STEP_W, SCSC_MULT, SCSC_MULT_W,
		SCSC_FIX, SCSC_QSCAN
	} scsc_state_t;
endpackage : scsc_pkg

// File: hdl/scsc_divider.sv
// sequential restoring divider used by the rate solver
`timescale 1ns/1ps
`default_nettype none
module scsc_divider
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic start,
	input wire logic [31:0] num,
	input wire logic [31:0] den,
	output logic done,
	output logic [31:0] quot
);
	logic [32:0] rem_r, rem_nxt;
	logic [31:0] quot_r, quot_nxt;
	logic [31:0] num_r, num_nxt;
	logic [31:0] den_r, den_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic run_r, run_nxt;
	logic done_r, done_nxt;

	always_comb
	begin
		logic [32:0] trial;
		trial = 33'h0_0000_0000;
		rem_nxt = rem_r;
		quot_nxt = quot_r;
		num_nxt = num_r;
		den_nxt = den_r;
		cnt_nxt = cnt_r;
		run_nxt = run_r;
		done_nxt = 1'b0;
		if (start)
		begin
			rem_nxt = 33'h0_0000_0000;
			num_nxt = num;
			den_nxt = den;
			cnt_nxt = 6'h20;
			run_nxt = 1'b1;
		end
		else if (run_r)
		begin
			trial = {rem_r[31:0], num_r[31]};
			num_nxt = {num_r[30:0], 1'b0};
			if (trial >= {1'b0, den_r})
			begin
				rem_nxt = trial - {1'b0, den_r};
				quot_nxt = {quot_r[30:0], 1'b1};
			end
			else
			begin
				rem_nxt = trial;
				quot_nxt = {quot_r[30:0], 1'b0};
			end
			cnt_nxt = cnt_r - 6'h01;
			if (cnt_r == 6'h01)
			begin
				run_nxt = 1'b0;
				done_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rem_r <= 33'h0_0000_0000;
			quot_r <= 32'h0000_0000;
			num_r <= 32'h0000_0000;
			den_r <= 32'h0000_0000;
			cnt_r <= 6'h00;
			run_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			rem_r <= rem_nxt;
			quot_r <= quot_nxt;
			num_r <= num_nxt;
			den_r <= den_nxt;
			cnt_r <= cnt_nxt;
			run_r <= run_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
	assign quot = quot_r;
endmodule : scsc_divider
`default_nettype wire

// File: tb/scsc_top_props.sv
// assertions on the ports of the sample clock source control block
`timescale 1ns/1ps
`default_nettype none
module scsc_top_props
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_rvalid,
	input wire logic [31:0] reg_rdata,
	input wire logic calc_busy,
	input wire logic loop_bypass,
	input wire logic loop_ref_external,
	input wire logic [31:0] loop_mult,
	input wire logic [11:0] quartz_div,
	input wire logic sample_clk_from_connector,
	input wire logic connector_clk_drive,
	input wire logic connector_termination
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence s_rate_wr;
		reg_wr && reg_addr == scsc_pkg::OFS_RATE_REQUEST;
	endsequence
	sequence s_solve;
		calc_busy ##[1:300] !calc_busy;
	endsequence
	a_rate_solve_bounded: assert property (s_rate_wr |=> s_solve)
		else $error("rate solve did not finish");
	a_rvalid_pulse: assert property (reg_rvalid == $past(reg_rd))
		else $error("read answer mistimed");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_bypass_follow: assert property ((reg_wr &&
		reg_addr == scsc_pkg::OFS_LOOP_ENABLE) |=>
		loop_bypass != $past(reg_wdata[0]))
		else $error("bypass does not follow loop enable");
	a_quartz_div_set: assert property ((loop_bypass && !calc_busy) |->
		quartz_div inside {12'h001, 12'h002, 12'h004, 12'h008, 12'h00a,
		12'h010, 12'h014, 12'h028, 12'h032, 12'h050, 12'h064, 12'h0c8,
		12'h190, 12'h1f4, 12'h320, 12'h3e8, 12'h7d0})
		else $error("quartz divider outside the set");
	a_loop_floor: assert property ((!calc_busy && !loop_bypass) |->
		loop_mult >= 32'h0000_0001)
		else $error("loop rate below floor");
	a_loop_ceiling: assert property ((!calc_busy && !loop_bypass &&
		!loop_ref_external) |-> loop_mult <= 32'h0001_e848)
		else $error("loop rate above ceiling");
	a_drive_internal: assert property (connector_clk_drive |->
		!sample_clk_from_connector && !loop_ref_external)
		else $error("clock driven while connector is an input");
	a_term_input: assert property (connector_termination |->
		sample_clk_from_connector || loop_ref_external)
		else $error("termination while connector is not an input");
endmodule : scsc_top_props
bind scsc_top scsc_top_props u_scsc_top_props (.mclk(mclk), .resetn(resetn),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
	.calc_busy(calc_busy), .loop_bypass(loop_bypass),
	.loop_ref_external(loop_ref_external), .loop_mult(loop_mult),
	.quartz_div(quartz_div),
	.sample_clk_from_connector(sample_clk_from_connector),
	.connector_clk_drive(connector_clk_drive),
	.connector_termination(connector_termination));
`default_nettype wire

// File: tb/scsc_ref_source.sv
// external reference source on the clock connector
`timescale 1ns/1ps
`default_nettype none
module scsc_ref_source
#(
	parameter logic [31:0] REF_HZ = 32'h0098_9680
)
(
	output logic [31:0] ref_hz
);
	// frequency fixed by REF_HZ, 10 MHz unless overridden and not range checked, reported as exact hertz
	assign ref_hz = REF_HZ;
endmodule : scsc_ref_source
`default_nettype wire

// File: tb/test_sample_clock_source_control.sv
// self-checking bench for the sample clock source control block
`timescale 1ns/1ps
`default_nettype none
module test_sample_clock_source_control;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [3:0] chan_enable = 4'h1;
	logic [31:0] reg_rdata, loop_mult, ref_hz, loop_prediv;
	logic reg_rvalid, calc_busy, loop_bypass, loop_ref_external;
	logic [11:0] quartz_div;
	logic sample_clk_from_connector, connector_clk_drive;
	logic connector_termination;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	scsc_top u_scsc_top (.mclk(mclk), .resetn(resetn), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.chan_enable(chan_enable), .calc_busy(calc_busy),
		.loop_bypass(loop_bypass), .loop_ref_external(loop_ref_external),
		.loop_mult(loop_mult), .loop_prediv(loop_prediv),
		.quartz_div(quartz_div),
		.sample_clk_from_connector(sample_clk_from_connector),
		.connector_clk_drive(connector_clk_drive),
		.connector_termination(connector_termination));
	scsc_ref_source u_scsc_ref_source (.ref_hz(ref_hz));
	always #4 mclk = ~mclk;
	task summarize;
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			summarize();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task settle;
		int i;
		repeat (2) @(posedge mclk);
		#1;
		for (i = 0; i < 400 && calc_busy !== 1'b0; i++)
		begin
			@(posedge mclk);
			#1;
		end
	endtask : settle
	task wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		settle();
	endtask : wr
	task rchk(input logic [15:0] a, input logic [31:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rvalid, 1);
		chk(reg_rdata, exp);
	endtask : rchk
	task t_defaults;
		rchk(scsc_pkg::OFS_LOOP_ENABLE, 1);
		rchk(scsc_pkg::OFS_RATE_REQUEST, 32'h0000_03e8);
		chk(loop_ref_external, 0);
		chk(connector_termination, 0);
		rchk(16'h4e00, 0);
		chk(calc_busy, 0);
		chk(connector_clk_drive, 0);
		chk(sample_clk_from_connector, 0);
		chk(loop_prediv, scsc_pkg::LOOP_PREDIV);
	endtask : t_defaults
	task t_loop_rate;
		wr(scsc_pkg::OFS_RATE_REQUEST, 32'h000f_4240);
		rchk(scsc_pkg::OFS_RATE_REQUEST, 32'h000f_4240);
		wr(scsc_pkg::OFS_RATE_REQUEST, 32'h0012_d687);
		rchk(scsc_pkg::OFS_RATE_REQUEST, 32'h0012_d838);
		chk(loop_mult, 32'h0000_04d3);
	endtask : t_loop_rate
	task t_limits;
		wr(scsc_pkg::OFS_RATE_REQUEST, 32'h0beb_c200);
		rchk(scsc_pkg::OFS_RATE_REQUEST, 32'h0773_5940);
		@(posedge mclk);
		chan_enable <= 4'h3;
		settle();
		rchk(scsc_pkg::OFS_RATE_REQUEST, 32'h03b9_aca0);
		wr(scsc_pkg::OFS_RATE_REQUEST, 32'h0000_0005);
		rchk(scsc_pkg::OFS_RATE_REQUEST, 32'h0000_03e8);
	endtask : t_limits
	task t_quartz;
		wr(scsc_pkg::OFS_LOOP_ENABLE, 0);
		chk(loop_bypass, 1);
		wr(scsc_pkg::OFS_RATE_REQUEST, 32'h002d_c6c0);
		rchk(scsc_pkg::OFS_RATE_REQUEST, 32'h002f_af08);
		chk(quartz_div, 32'h0000_0028);
		wr(scsc_pkg::OFS_LOOP_ENABLE, 1);
		chk(loop_bypass, 0);
	endtask : t_quartz
	task t_ext_ref;
		wr(scsc_pkg::OFS_REFERENCE, ref_hz);
		chk(loop_ref_external, 1);
		rchk(scsc_pkg::OFS_REFERENCE, ref_hz);
		wr(scsc_pkg::OFS_RATE_REQUEST, 32'h017d_7840);
		rchk(scsc_pkg::OFS_RATE_REQUEST, 32'h017d_7840);
		chk(loop_mult, 32'h0001_86a0);
		wr(scsc_pkg::OFS_TERMINATION, 1);
		wr(scsc_pkg::OFS_CLOCK_OUT, 1);
		chk(connector_termination, 1);
		chk(connector_clk_drive, 0);
		rchk(scsc_pkg::OFS_TERMINATION, 1);
		rchk(scsc_pkg::OFS_CLOCK_OUT, 1);
		wr(scsc_pkg::OFS_REFERENCE, 0);
		chk(connector_termination, 0);
		chk(connector_clk_drive, 1);
		wr(scsc_pkg::OFS_DIRECT_EXT, 1);
		chk(sample_clk_from_connector, 1);
		chk(connector_clk_drive, 0);
		chk(connector_termination, 1);
		rchk(scsc_pkg::OFS_DIRECT_EXT, 1);
	endtask : t_ext_ref
	task t_reset;
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		settle();
		rchk(scsc_pkg::OFS_LOOP_ENABLE, 1);
		rchk(scsc_pkg::OFS_RATE_REQUEST, 32'h0000_03e8);
		rchk(scsc_pkg::OFS_REFERENCE, 0);
		chk(sample_clk_from_connector, 0);
		chk(connector_clk_drive, 0);
		chk(connector_termination, 0);
	endtask : t_reset
	initial
	begin
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		settle();
		t_defaults();
		t_loop_rate();
		t_limits();
		t_quartz();
		t_ext_ref();
		t_reset();
		summarize();
	end
endmodule : test_sample_clock_source_control
`default_nettype wire
